// ### dv/loop_monitor_top_bench.sv
// Self-checking bench of the loop supervision block.
// Assumes a scaled millisecond tick of one clock.
`timescale 1ns/1ps
`include "loop_mon_map.svh"
`define CHK(n, e, s) tests_run++; if ((s) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end
// ****
// Bench
// ****
module loop_monitor_top_bench;
    logic i_core_clk = '0, i_sys_rst = '1, i_wb_cyc = '0, i_wb_stb = '0, i_wb_we = '0;
    logic [7:0] i_wb_adr = '0;
    logic [3:0] i_wb_sel = '1;
    logic [31:0] i_wb_dat = '0, o_wb_dat, rd;
    logic o_wb_ack, o_backlight, i_up_button = '0, i_down_button = '0;
    logic i_channel_select_button = '0, i_menu_advance_button = '0;
    logic [15:0] i_ch0_ind, i_ch1_ind, v, lvl0 = 16'h4000;
    logic [1:0] i_ind_vld, i_call_out = '0, i_delay_timing = '0, i_ext_timing = '0, c;
    logic [1:0] i_pending = '0, o_detect_led, o_fail_safe, o_low_fault_code;
    logic [1:0] o_high_fault_code, o_operational;
    int n_mismatch = 0, tests_run = 0;
    logic [7:0] ra[4] = '{`REG_CTRL, `REG_CFG0, `REG_CFG1, 8'h14};
    logic [31:0] rv[4] = '{`CTRL_RST, `CFG0_RST, `CFG1_RST, 32'h0000_0000};
    logic [15:0] lv[8] = '{16'h2000, 16'h4000, 16'h6000, 16'h4000, 16'h0050, 16'h4000,
        16'hF800, 16'h4000};
    loop_partner u_loop_partner (.i_core_clk, .i_lvl0(lvl0), .i_lvl1(16'h4000),
        .o_ch0_ind(i_ch0_ind), .o_ch1_ind(i_ch1_ind), .o_ind_vld(i_ind_vld));
    loop_monitor_top #(.TICK_CYC(1), .BL_MS(50), .FULL_MS(40)) u_loop_monitor_top (.*,
        .o_channel_select_button_sel(), .o_vehicle_detect(), .o_ch0_cfg(), .o_ch1_cfg(), .o_option_bits());
    // Fault code from a level against the 16'h4000 baseline; bit1 high, bit0 low.
    function automatic logic [1:0] fault_exp(input logic [15:0] x);
        return {x > 16'h5000, x < 16'h3000};
    endfunction
    // One classic cycle; read data is taken at the edge that sees ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wb_cyc <= '1;
        i_wb_stb <= '1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        @(posedge i_core_clk iff o_wb_ack);
        rd = o_wb_dat;
        i_wb_cyc <= '0;
        i_wb_stb <= '0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    // Cuts off a hang well past the expected run.
    initial begin
        #1_000_000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h0000_49f6));
        repeat (4) @(posedge i_core_clk);
        i_sys_rst <= '0;
        foreach (ra[i]) begin
            wb('0, ra[i], '0);
            `CHK("reg", rv[i], rd)
        end
        repeat (24) @(posedge i_core_clk);
        `CHK("tuned", 2'h3, o_operational)
        $display("defaults done");
        foreach (lv[i]) begin
            lvl0 <= lv[i];
            repeat (24) @(posedge i_core_clk);
            c = fault_exp(lv[i]);
            `CHK("low", c[0], o_low_fault_code[0])
            `CHK("high", c[1], o_high_fault_code[0])
            `CHK("fail", |c, o_fail_safe[0])
        end
        wb('0, `REG_STATUS, '0);
        `CHK("latch", 1'h1, rd[4])
        wb('0, `REG_FAILCNT, '0);
        `CHK("count", 8'h04, rd[7:0])
        repeat (100) begin
            lvl0 <= 16'h2000;
            repeat (16) @(posedge i_core_clk);
            lvl0 <= 16'h4000;
            repeat (16) @(posedge i_core_clk);
        end
        wb('0, `REG_FAILCNT, '0);
        `CHK("sat", `FAIL_CNT_MAX, rd[7:0])
        wb('1, `REG_CFG0, 32'h0400_0053);
        repeat (24) @(posedge i_core_clk);
        wb('0, `REG_FAILCNT, '0);
        `CHK("cleared", 8'h00, rd[7:0])
        `CHK("retuned", 1'h1, o_operational[0])
        $display("faults done");
        repeat (20) begin
            v = 16'($urandom);
            {i_channel_select_button, i_menu_advance_button, i_down_button, i_up_button} <= v[11:8];
            {i_pending, i_ext_timing, i_delay_timing, i_call_out} <= v[7:0];
            repeat (3) @(posedge i_core_clk);
            `CHK("led", v[1] | v[3] | v[5] | v[7], o_detect_led[1])
        end
        {i_channel_select_button, i_menu_advance_button, i_down_button, i_up_button} <= '0;
        repeat (4) @(posedge i_core_clk);
        i_up_button <= '1;
        @(posedge i_core_clk);
        i_up_button <= '0;
        repeat (40) @(posedge i_core_clk);
        `CHK("lit", 1'h1, o_backlight)
        repeat (30) @(posedge i_core_clk);
        `CHK("dark", 1'h0, o_backlight)
        $display("panel done");
        complete_run();
    end
endmodule

// ### dv/loop_monitor_top_properties.sv
// Port-level checks of the loop supervision block.
// Assumes settings stay still while a channel is failed.
`timescale 1ns/1ps
`include "loop_mon_map.svh"
// ****
// Checker
// ****
module loop_monitor_top_properties (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [15:0] i_ch0_ind,
    input wire logic [1:0] i_ind_vld,
    input wire logic i_up_button,
    input wire logic o_backlight,
    input wire logic [1:0] o_fail_safe,
    input wire logic [1:0] o_low_fault_code,
    input wire logic [1:0] o_high_fault_code,
    input wire logic [31:0] o_ch0_cfg,
    input wire logic [31:0] o_ch1_cfg
);
    // One domain, so clock and reset are stated once.
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    property p_bl; $rose(i_up_button) |-> ##[1:6] o_backlight; endproperty
    a_bl: assert property (p_bl) else $error("backlight not lit");
    property p_lo; i_ind_vld[0] && i_ch0_ind < `IND_MIN |-> ##2 o_low_fault_code[0]; endproperty
    a_lo: assert property (p_lo) else $error("short not flagged");
    property p_hi; i_ind_vld[0] && i_ch0_ind > `IND_MAX |-> ##2 o_high_fault_code[0]; endproperty
    a_hi: assert property (p_hi) else $error("open not flagged");
    property p_code; o_low_fault_code[0] || o_high_fault_code[0] |-> o_fail_safe[0]
        && !(o_low_fault_code[0] && o_high_fault_code[0]); endproperty
    a_code: assert property (p_code) else $error("bad fault code");
    property p_hold; o_fail_safe[0] && !i_ind_vld[0] && !$past(i_ind_vld[0]) |=> o_fail_safe[0];
    endproperty
    a_hold: assert property (p_hold) else $error("fault dropped");
    property p_heal; $fell(o_fail_safe[0]) |-> !o_low_fault_code[0] && !o_high_fault_code[0];
    endproperty
    a_heal: assert property (p_heal) else $error("code stuck");
    property p_dflt; $fell(i_sys_rst) |-> o_ch0_cfg == `CFG0_RST && o_ch1_cfg == `CFG1_RST;
    endproperty
    a_dflt: assert property (p_dflt) else $error("bad defaults");
    property p_sat; o_wb_ack && i_wb_adr == `REG_FAILCNT |-> o_wb_dat[7:0] <= `FAIL_CNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("count wrapped");
endmodule
bind loop_monitor_top loop_monitor_top_properties u_loop_monitor_top_properties (.*);

// ### dv/loop_partner.sv
// Loop front-end model: one inductance word per channel every eight clocks.
// Assumes the bench sets the loop level and holds it as long as it wants.
`timescale 1ns/1ps
// ****
// Model
// ****
module loop_partner (
    input wire logic i_core_clk,
    input wire logic [15:0] i_lvl0,
    input wire logic [15:0] i_lvl1,
    output logic [15:0] o_ch0_ind,
    output logic [15:0] o_ch1_ind,
    output logic [1:0] o_ind_vld
);
    logic [2:0] ph_r = 3'h0;
    // Between samples the word is inverted, so junk shows without valid.
    always_ff @(posedge i_core_clk) begin
        ph_r <= ph_r + 3'h1;
        o_ind_vld <= {2{ph_r == 3'h7}};
        o_ch0_ind <= (ph_r == 3'h7) ? i_lvl0 : ~i_lvl0;
        o_ch1_ind <= (ph_r == 3'h7) ? i_lvl1 : ~i_lvl1;
    end
endmodule

// ### inc/loop_mon_map.svh
// Offsets, field positions, reset values and timing figures of the
// two-channel loop supervision block.
// Assumes a single 20 MHz core clock and a classic Wishbone register bus.
`ifndef LOOP_MON_MAP_SVH
`define LOOP_MON_MAP_SVH

// ****
// Clock and times
// ****
`define CLK_PERIOD_NS 50
`define MS_NS 1000000
`define BACKLIGHT_MIN 15
`define TUNE_MS 2000
`define FULL_SENS_S 30
`define CHANNEL_SELECT_BUTTON_HOLD_S 3
`define FLASH_PER_S 3
`define RESP_FILT_MS 133
`define RESP_L1_5_MS 20
`define RESP_L6_MS 27
`define RESP_L7_MS 42
`define RESP_L8_MS 72
`define RESP_L9_MS 133

// ****
// Loop measurement limits and detection threshold
// ****
`define IND_MIN 16'h0100
`define IND_MAX 16'hF000
`define THR_MULT 5'h1A
`define THR_SHIFT_BASE 5'h0B
`define SENS_CALL 4'hA
`define SENS_REDUCE 4'h3
`define FAIL_CNT_MAX 8'h63

// ****
// Register offsets, fields and reset values
// ****
`define REG_CTRL 8'h00
`define REG_CFG0 8'h04
`define REG_CFG1 8'h08
`define REG_STATUS 8'h0C
`define REG_FAILCNT 8'h10
`define CTRL_FILT_DIS 0
`define CFG_FREQ_LSB 0
`define CFG_FREQ_MSB 3
`define CFG_SENS_LSB 4
`define CFG_SENS_MSB 7
`define CTRL_RST 32'h0000_0000
`define CFG0_RST 32'h0400_0063
`define CFG1_RST 32'h0400_0067

`endif

// ### inc/loop_mon_pkg.sv
// Types shared by the loop supervision block.
// Assumes loop_mon_map.svh supplies every number.
package loop_mon_pkg;
    typedef enum logic [1:0] {CH_TUNE, CH_RUN, CH_FAIL} channel_select_button_state_t;
endpackage

// ### logic/loop_eval.sv
// Per-channel comparison of a loop sample against range and baseline.
// Assumes samples scale with loop inductance; purely combinational.
`timescale 1ns/1ps
`include "loop_mon_map.svh"
module loop_eval (
    input wire logic [15:0] i_sample,
    input wire logic [15:0] i_base,
    input wire logic i_base_ok,
    input wire logic [3:0] i_sens,
    output logic o_low,
    output logic o_high,
    output logic o_over
);
    logic [15:0] quarter;
    logic [15:0] lo_lim;
    logic [16:0] hi_lim;
    logic [20:0] prod;
    logic [20:0] thr;
    logic [15:0] drop;
    logic [4:0] shamt;

    // A quarter of the baseline marks a rapid change either way.
    assign quarter = i_base >> 2;
    assign lo_lim = i_base - quarter;
    assign hi_lim = {1'b0, i_base} + {1'b0, quarter};
    assign o_low = (i_sample < `IND_MIN) || (i_base_ok && i_sample < lo_lim);
    assign o_high = (i_sample > `IND_MAX) || (i_base_ok && {1'b0, i_sample} > hi_lim);

    // Threshold halves with each level: 26/2^12 of the baseline at level 1.
    assign prod = i_base * `THR_MULT;
    assign shamt = `THR_SHIFT_BASE + {1'b0, i_sens};
    assign thr = prod >> shamt;
    assign drop = i_base - i_sample;
    assign o_over = i_base_ok && (i_sens != 4'h0) && (i_sample < i_base)
        && ({5'h00, drop} >= thr);
endmodule

// ### logic/loop_monitor_top.sv
// Two-channel loop supervision: fault monitor, indicators, tuning timers,
// backlight timeout, settings registers on a classic Wishbone slave.
// Assumes the front end gives one inductance word per valid pulse and
// the call timing logic reports its states on the same clock.
//
// How it works
// - Any button press restarts 15-minute backlight
// - Lamp lit on call, timing, pending, fail
// - Channel tuned and detecting within two seconds
// - Full sensitivity after 30 s running
// - Out-of-range or 25% jump enters fail-safe
// - Low code for drop/short, high for rise/open
// - Fail-safe holds while fault remains
// - Reset retunes and leaves fault if good
// - Fault latches 3 Hz flash until reset
// - Self-heal clears fail, flash stays
// - Fault counter per channel, cleared by reset
// - Mixed sensitivities average the response times
// - Factory defaults loaded at power-up
// - Three-second hold or setting change resets channel
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`include "loop_mon_map.svh"
module loop_monitor_top #(
    parameter int TICK_CYC = `MS_NS / `CLK_PERIOD_NS,
    parameter int BL_MS = `BACKLIGHT_MIN * 60 * 1000,
    parameter int FULL_MS = `FULL_SENS_S * 1000
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [15:0] i_ch0_ind,
    input wire logic [15:0] i_ch1_ind,
    input wire logic [1:0] i_ind_vld,
    input wire logic [1:0] i_call_out,
    input wire logic [1:0] i_delay_timing,
    input wire logic [1:0] i_ext_timing,
    input wire logic [1:0] i_pending,
    input wire logic i_channel_select_button,
    input wire logic i_menu_advance_button,
    input wire logic i_up_button,
    input wire logic i_down_button,
    output logic o_backlight,
    output logic o_channel_select_button_sel,
    output logic [1:0] o_detect_led,
    output logic [1:0] o_fail_safe,
    output logic [1:0] o_low_fault_code,
    output logic [1:0] o_high_fault_code,
    output logic [1:0] o_vehicle_detect,
    output logic [1:0] o_operational,
    output logic [31:0] o_ch0_cfg,
    output logic [31:0] o_ch1_cfg,
    output logic [31:0] o_option_bits
);
    localparam int HOLD_MS = `CHANNEL_SELECT_BUTTON_HOLD_S * 1000;
    localparam int FLASH_HALF_MS = 1000 / (2 * `FLASH_PER_S);

    // ****
    // Millisecond tick
    // ****
    logic [15:0] tick_cnt_r;
    logic tick_r;
    wire tick_wrap = (tick_cnt_r == 16'(TICK_CYC - 1));

    // All slow timers count this tick so their widths stay modest.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_wrap ? 16'h0000 : tick_cnt_r + 16'h0001;
            tick_r <= tick_wrap;
        end
    end

    // ****
    // Front-panel buttons and backlight
    // ****
    logic [3:0] btn_s;
    logic [3:0] btn_d_r;
    logic [19:0] bl_cnt_r;
    logic [11:0] hold_cnt_r;
    logic hold_done_r;
    logic sel_r;

    sync2 #(.W(4)) u_btn_sync (
        .i_clk(i_core_clk),
        .i_rst(i_sys_rst),
        .i_d({i_down_button, i_up_button, i_menu_advance_button,
              i_channel_select_button}),
        .o_q(btn_s)
    );

    wire any_press = |(btn_s & ~btn_d_r);
    wire sel_fall = btn_d_r[0] & ~btn_s[0];
    wire hold_fire = btn_s[0] && tick_r && !hold_done_r
        && (hold_cnt_r == 12'(HOLD_MS - 1));
    wire [19:0] bl_nxt = any_press ? 20'(BL_MS) :
        ((tick_r && bl_cnt_r != 20'h0_0000) ? bl_cnt_r - 20'h0_0001 : bl_cnt_r);

    // A press always reloads the full timeout, even while already lit.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            btn_d_r <= 4'h0;
            bl_cnt_r <= 20'h0_0000;
            o_backlight <= 1'b0;
        end else begin
            btn_d_r <= btn_s;
            bl_cnt_r <= bl_nxt;
            o_backlight <= (bl_nxt != 20'h0_0000);
        end
    end

    // A short press toggles the channel; a long hold resets it instead.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold_cnt_r <= 12'h000;
            hold_done_r <= 1'b0;
            sel_r <= 1'b0;
        end else if (!btn_s[0]) begin
            hold_cnt_r <= 12'h000;
            hold_done_r <= 1'b0;
            if (sel_fall && !hold_done_r) begin
                sel_r <= ~sel_r;
            end
        end else if (hold_fire) begin
            hold_done_r <= 1'b1;
        end else if (tick_r && !hold_done_r) begin
            hold_cnt_r <= hold_cnt_r + 12'h001;
        end
    end

    // ****
    // Wishbone slave and settings
    // ****
    logic ack_r;
    logic [31:0] ctrl_r;
    logic [31:0] cfg0_r;
    logic [31:0] cfg1_r;
    logic [1:0] channel_select_button_rst_r;
    logic [31:0] rd_dat;
    logic [31:0] status_w;
    logic [7:0] fcnt_w [2];

    wire wb_req = i_wb_cyc & i_wb_stb;
    wire wr = wb_req & ack_r & i_wb_we;
    wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                         {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire wr_ctrl = wr && (i_wb_adr == `REG_CTRL);
    wire wr_cfg0 = wr && (i_wb_adr == `REG_CFG0);
    wire wr_cfg1 = wr && (i_wb_adr == `REG_CFG1);
    wire [31:0] ctrl_new = (ctrl_r & ~wmask) | (i_wb_dat & wmask);
    wire [31:0] cfg0_new = (cfg0_r & ~wmask) | (i_wb_dat & wmask);
    wire [31:0] cfg1_new = (cfg1_r & ~wmask) | (i_wb_dat & wmask);

    // Frequency and sensitivity share the low byte of each channel word.
    wire chg0 = wr_cfg0 && (cfg0_new[`CFG_SENS_MSB:`CFG_FREQ_LSB]
        != cfg0_r[`CFG_SENS_MSB:`CFG_FREQ_LSB]);
    wire chg1 = wr_cfg1 && (cfg1_new[`CFG_SENS_MSB:`CFG_FREQ_LSB]
        != cfg1_r[`CFG_SENS_MSB:`CFG_FREQ_LSB]);
    wire filt_chg = wr_ctrl && (ctrl_new[`CTRL_FILT_DIS] != ctrl_r[`CTRL_FILT_DIS]);
    wire [1:0] channel_select_button_rst_nxt = {chg1 | filt_chg | (hold_fire & sel_r),
                               chg0 | filt_chg | (hold_fire & ~sel_r)};

    // Unmapped offsets answer with zero and ignore writes.
    assign rd_dat = (i_wb_adr == `REG_CTRL) ? ctrl_r :
                    (i_wb_adr == `REG_CFG0) ? cfg0_r :
                    (i_wb_adr == `REG_CFG1) ? cfg1_r :
                    (i_wb_adr == `REG_STATUS) ? status_w :
                    (i_wb_adr == `REG_FAILCNT) ? {16'h0000, fcnt_w[1], fcnt_w[0]} :
                    32'h0000_0000;

    // Ack follows one edge after the request; writes land on the ack edge.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack_r <= 1'b0;
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            ack_r <= wb_req & ~ack_r;
            o_wb_ack <= wb_req & ~ack_r;
            o_wb_dat <= (wb_req & ~ack_r) ? rd_dat : 32'h0000_0000;
        end
    end

    // Settings start from factory values at power-up.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_r <= `CTRL_RST;
            cfg0_r <= `CFG0_RST;
            cfg1_r <= `CFG1_RST;
            channel_select_button_rst_r <= 2'b00;
        end else begin
            ctrl_r <= wr_ctrl ? ctrl_new : ctrl_r;
            cfg0_r <= wr_cfg0 ? cfg0_new : cfg0_r;
            cfg1_r <= wr_cfg1 ? cfg1_new : cfg1_r;
            channel_select_button_rst_r <= channel_select_button_rst_nxt;
        end
    end

    // ****
    // Response time shared by both channels
    // ****
    function automatic logic [7:0] resp_ms(input logic [3:0] s, input logic fd);
        logic [7:0] r;
        r = 8'(`RESP_FILT_MS);
        if (fd) begin
            case (s)
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5: r = 8'(`RESP_L1_5_MS);
                4'h6: r = 8'(`RESP_L6_MS);
                4'h7: r = 8'(`RESP_L7_MS);
                4'h8: r = 8'(`RESP_L8_MS);
                default: r = 8'(`RESP_L9_MS);
            endcase
        end
        return r;
    endfunction

    wire [3:0] sens0 = cfg0_r[`CFG_SENS_MSB:`CFG_SENS_LSB];
    wire [3:0] sens1 = cfg1_r[`CFG_SENS_MSB:`CFG_SENS_LSB];
    wire fdis = ctrl_r[`CTRL_FILT_DIS];
    wire [7:0] r0 = resp_ms(sens0, fdis);
    wire [7:0] r1 = resp_ms(sens1, fdis);
    wire [8:0] r_sum = {1'b0, r0} + {1'b0, r1};
    // Channels share measurement time, so differing levels average.
    wire [7:0] resp = (sens0 == sens1) ? r0 : r_sum[8:1];

    // ****
    // Flash pattern for latched faults
    // ****
    logic [7:0] flash_cnt_r;
    logic flash_ph_r;
    wire flash_wrap = tick_r && (flash_cnt_r == 8'(FLASH_HALF_MS - 1));

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flash_cnt_r <= 8'h00;
            flash_ph_r <= 1'b0;
        end else begin
            flash_cnt_r <= flash_wrap ? 8'h00 : (tick_r ? flash_cnt_r + 8'h01 : flash_cnt_r);
            flash_ph_r <= flash_wrap ? ~flash_ph_r : flash_ph_r;
        end
    end

    // ****
    // Per-channel supervision
    // ****
    wire [15:0] ind_w [2];
    wire [3:0] sens_w [2];
    logic [1:0] fail_w;
    logic [1:0] lo_w;
    logic [1:0] hi_w;
    logic [1:0] latch_w;
    logic [1:0] det_w;
    logic [1:0] oper_w;
    logic [1:0] full_w;

    assign ind_w[0] = i_ch0_ind;
    assign ind_w[1] = i_ch1_ind;
    assign sens_w[0] = sens0;
    assign sens_w[1] = sens1;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        loop_mon_pkg::channel_select_button_state_t st_r;
        loop_mon_pkg::channel_select_button_state_t st_nxt;
        logic [15:0] base_r;
        logic [15:0] base_nxt;
        logic bok_r;
        logic bok_nxt;
        logic lo_r;
        logic lo_nxt;
        logic hi_r;
        logic hi_nxt;
        logic latch_r;
        logic [7:0] cnt_r;
        logic [10:0] tune_r;
        logic [14:0] run_r;
        logic occ_r;
        logic [7:0] occ_cnt_r;
        logic low;
        logic high;
        logic over;

        wire vld = i_ind_vld[c];
        wire rst_ch = channel_select_button_rst_r[c];
        wire full = (run_r == 15'(FULL_MS));
        // Until fully settled, detection runs a few levels coarser.
        wire [3:0] eff_sens = (full || sens_w[c] <= `SENS_REDUCE) ? sens_w[c] :
            sens_w[c] - `SENS_REDUCE;
        wire fail_in = (st_r != loop_mon_pkg::CH_FAIL)
            && (st_nxt == loop_mon_pkg::CH_FAIL);

        loop_eval u_eval (
            .i_sample(ind_w[c]),
            .i_base(base_r),
            .i_base_ok(bok_r),
            .i_sens(eff_sens),
            .o_low(low),
            .o_high(high),
            .o_over(over)
        );

        // Tune, run and fail-safe sequencing of one channel.
        always_comb begin
            st_nxt = st_r;
            base_nxt = base_r;
            bok_nxt = bok_r;
            lo_nxt = lo_r;
            hi_nxt = hi_r;
            case (st_r)
                loop_mon_pkg::CH_TUNE: begin
                    if (vld && !low && !high) begin
                        base_nxt = ind_w[c];
                        bok_nxt = 1'b1;
                        st_nxt = loop_mon_pkg::CH_RUN;
                    end else if (vld) begin
                        lo_nxt = low;
                        hi_nxt = high;
                        st_nxt = loop_mon_pkg::CH_FAIL;
                    end else if (tick_r && tune_r == 11'(`TUNE_MS - 1)) begin
                        lo_nxt = 1'b0;
                        hi_nxt = 1'b1;
                        st_nxt = loop_mon_pkg::CH_FAIL;
                    end
                end
                loop_mon_pkg::CH_RUN: begin
                    if (vld && (low || high)) begin
                        lo_nxt = low;
                        hi_nxt = high;
                        st_nxt = loop_mon_pkg::CH_FAIL;
                    end else if (vld && !over && ind_w[c] > base_r) begin
                        base_nxt = base_r + 16'h0001;
                    end else if (vld && !over && ind_w[c] < base_r) begin
                        base_nxt = base_r - 16'h0001;
                    end
                end
                loop_mon_pkg::CH_FAIL: begin
                    if (vld && !low && !high) begin
                        lo_nxt = 1'b0;
                        hi_nxt = 1'b0;
                        st_nxt = loop_mon_pkg::CH_RUN;
                        if (!bok_r) begin
                            base_nxt = ind_w[c];
                            bok_nxt = 1'b1;
                        end
                    end else if (vld) begin
                        lo_nxt = low;
                        hi_nxt = high;
                    end
                end
                default: st_nxt = loop_mon_pkg::CH_TUNE;
            endcase
            if (rst_ch) begin
                st_nxt = loop_mon_pkg::CH_TUNE;
                bok_nxt = 1'b0;
                lo_nxt = 1'b0;
                hi_nxt = 1'b0;
            end
        end

        always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                st_r <= loop_mon_pkg::CH_TUNE;
                base_r <= 16'h0000;
                bok_r <= 1'b0;
                lo_r <= 1'b0;
                hi_r <= 1'b0;
            end else begin
                st_r <= st_nxt;
                base_r <= base_nxt;
                bok_r <= bok_nxt;
                lo_r <= lo_nxt;
                hi_r <= hi_nxt;
            end
        end

        // Fault entry sets the flash latch and counts; entry beats a clear.
        always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                latch_r <= 1'b0;
                cnt_r <= 8'h00;
            end else if (fail_in) begin
                latch_r <= 1'b1;
                cnt_r <= (cnt_r == `FAIL_CNT_MAX) ? cnt_r : cnt_r + 8'h01;
            end else if (rst_ch) begin
                latch_r <= 1'b0;
                cnt_r <= 8'h00;
            end
        end

        // Tuning watchdog, settling timer and occupancy timing.
        always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                tune_r <= 11'h000;
                run_r <= 15'h0000;
                occ_r <= 1'b0;
                occ_cnt_r <= 8'h00;
            end else begin
                tune_r <= (rst_ch || st_r != loop_mon_pkg::CH_TUNE) ? 11'h000 :
                    (tick_r ? tune_r + 11'h001 : tune_r);
                run_r <= rst_ch ? 15'h0000 :
                    ((tick_r && !full && st_r != loop_mon_pkg::CH_TUNE) ?
                     run_r + 15'h0001 : run_r);
                occ_r <= (st_r != loop_mon_pkg::CH_RUN) ? 1'b0 : (vld ? over : occ_r);
                occ_cnt_r <= !occ_r ? 8'h00 :
                    ((tick_r && occ_cnt_r < resp) ? occ_cnt_r + 8'h01 : occ_cnt_r);
            end
        end

        assign fail_w[c] = (st_r == loop_mon_pkg::CH_FAIL);
        assign lo_w[c] = lo_r;
        assign hi_w[c] = hi_r;
        assign latch_w[c] = latch_r;
        assign oper_w[c] = (st_r != loop_mon_pkg::CH_TUNE);
        assign full_w[c] = full;
        assign fcnt_w[c] = cnt_r;
        // A failed loop places a fail-safe call.
        assign det_w[c] = fail_w[c] || ((st_r == loop_mon_pkg::CH_RUN)
            && (sens_w[c] >= `SENS_CALL || (occ_r && occ_cnt_r >= resp)));
    end

    assign status_w = {14'h0000, sel_r, o_backlight,
                       1'b0, det_w[1], full_w[1], latch_w[1],
                       hi_w[1], lo_w[1], fail_w[1], oper_w[1],
                       1'b0, det_w[0], full_w[0], latch_w[0],
                       hi_w[0], lo_w[0], fail_w[0], oper_w[0]};

    // ****
    // Registered outputs
    // ****
    // The lamp shows activity unless a latched fault forces the flash.
    wire [1:0] led_nxt = (latch_w & {2{flash_ph_r}})
        | (~latch_w & (i_call_out | i_delay_timing | i_ext_timing
                       | i_pending | fail_w));

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_detect_led <= 2'b00;
            o_fail_safe <= 2'b00;
            o_low_fault_code <= 2'b00;
            o_high_fault_code <= 2'b00;
            o_vehicle_detect <= 2'b00;
            o_operational <= 2'b00;
            o_channel_select_button_sel <= 1'b0;
        end else begin
            o_detect_led <= led_nxt;
            o_fail_safe <= fail_w;
            o_low_fault_code <= lo_w;
            o_high_fault_code <= hi_w;
            o_vehicle_detect <= det_w;
            o_operational <= oper_w;
            o_channel_select_button_sel <= sel_r;
        end
    end

    // Settings are exported to the call timing logic.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_ch0_cfg <= `CFG0_RST;
            o_ch1_cfg <= `CFG1_RST;
            o_option_bits <= `CTRL_RST;
        end else begin
            o_ch0_cfg <= cfg0_r;
            o_ch1_cfg <= cfg1_r;
            o_option_bits <= ctrl_r;
        end
    end
endmodule

// ### logic/sync2.sv
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes the reader uses only the second stage.
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // The first stage feeds only the second one.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            o_q <= '0;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule
